/* File: rtl/rsc_top.sv */
// Purpose: Flag and control registers of a battery-backed clock/calendar.
// Assumes: Asynchronous byte bus; event inputs come from logic on mclk_i.
// Notes:   Open-drain pins are output enables; high enable pulls the pin low.
module rsc_top #(
   parameter int unsigned RST_PULSE_CYC = rsc_pkg::RST_PULSE_CYC
) (
   input  wire logic                      mclk_i,          // System clock.
   input  wire logic                      reset_i,         // Power-on reset pulse.
   input  wire logic                      ce_n_i,          // Chip select, low.
   input  wire logic                      oe_n_i,          // Read strobe, low.
   input  wire logic                      we_n_i,          // Write strobe, low.
   input  wire logic [rsc_pkg::ADDR_W-1:0] addr_i,         // Byte address.
   input  wire logic [7:0]                data_i,          // Data pins in.
   output logic      [7:0]                data_o,          // Data pins out.
   output logic                           data_oe_o,       // Data drive enable.
   input  wire logic                      main_batt_low_i, // Primary battery low.
   input  wire logic                      aux_batt_low_i,  // Auxiliary battery low.
   input  wire logic                      power_fail_i,    // Supply below limit.
   input  wire logic                      alarm_match_i,   // Alarm compare pulse.
   input  wire logic                      kick_event_i,    // Kickstart pulse.
   input  wire logic                      wdog_timeout_i,  // Watchdog expiry pulse.
   input  wire logic                      sec_tick_i,      // Once-per-second tick.
   input  wire logic                      ram_access_i,    // RAM data access pulse.
   output logic                           advance_o,       // Advance time counts.
   output logic                           ram_addr_inc_o,  // Step RAM address.
   output logic                           wdog_reload_o,   // Host write, reload.
   output logic                           xtal_12p5_o,     // Crystal load select.
   output logic                           osc_run_o,       // Oscillator enable.
   output logic                           irq_oe_o,        // Interrupt pulls low.
   output logic                           pwr_oe_o,        // Power request low.
   output logic                           wdog_rst_n_o     // Watchdog reset, low.
);
   import rsc_pkg::*;

   typedef struct packed {
      logic [7:0]        ctl;
      logic              power_fail_output_keep;
      logic              power_hold_release;
      logic              alarm_match_flag;
      logic              kick_event_flag;
      logic              watchdog_timeout_flag;
      logic              osc_stop_n;
      logic              wv;
      logic [ADDR_W-1:0] wa;
      logic [7:0]        wd;
      logic              armed;
      logic [ADDR_W-1:0] ra;
      logic [1:0]        stab;
      logic [7:0]        rdata;
      logic              reload;
      logic              act_p;
   } rsc_st_t;

   rsc_st_t st_q;
   rsc_st_t st_d;

   logic [ADDR_W-1:0] addr_s;
   logic [7:0]        data_s;
   logic              ce_n_s;
   logic              oe_n_s;
   logic              we_n_s;
   logic              mbl_s;
   logic              abl_s;
   logic              pf_s;
   logic              rd_act;
   logic              wr_act;
   logic              interrupt_pending_flag;
   logic [7:0]        flags_v;

   rsc_wd_if wd_if ();

   // Bus, battery and supply pins come from outside the clock domain.
   rsc_pin_sync #(
      .W    (19),
      .INIT (19'h70000)
   ) u_sync (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .async_i ({ce_n_i, oe_n_i, we_n_i, addr_i, data_i,
                 main_batt_low_i, aux_batt_low_i, power_fail_i}),
      .sync_o  ({ce_n_s, oe_n_s, we_n_s, addr_s, data_s,
                 mbl_s, abl_s, pf_s})
   );

   rsc_rst_pulse #(
      .CYC (RST_PULSE_CYC)
   ) u_pulse (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .wd      (wd_if.pulse)
   );

   // Bus cycle decode; a write strobe overrides the read strobe.
   assign rd_act = !ce_n_s && !oe_n_s && we_n_s;
   assign wr_act = !ce_n_s && !we_n_s;

   // Pending flag is a pure function of the flags and their enables.
   assign interrupt_pending_flag = (st_q.alarm_match_flag & st_q.ctl[CB_TIE])
               | (st_q.kick_event_flag & st_q.ctl[CB_KIE])
               | (st_q.watchdog_timeout_flag & st_q.ctl[CB_WDE]);

   // Flag register image, battery bits from the synchronised pins.
   assign flags_v = {mbl_s, abl_s, st_q.power_fail_output_keep, st_q.power_hold_release,
                     st_q.alarm_match_flag, st_q.kick_event_flag, st_q.watchdog_timeout_flag, interrupt_pending_flag};

   // Single-shot start only when armed, steered and not already running.
   assign wd_if.start = wdog_timeout_i && st_q.ctl[CB_WDE]
                        && st_q.ctl[CB_WDS] && !wd_if.active;

   // Next-state logic. Clears come first so that hardware sets win.
   always_comb begin
      st_d        = st_q;
      st_d.reload = 1'b0;
      st_d.act_p  = wd_if.active;
      st_d.ra     = addr_s;
      st_d.rdata  = (addr_s == ADDR_CTRL) ? st_q.ctl : flags_v;

      // Count how long the read address has stood still.
      if (rd_act && addr_s == st_q.ra) begin
         st_d.stab = (st_q.stab == 2'h3) ? 2'h3 : st_q.stab + 2'h1;
      end else begin
         st_d.stab = {1'b0, rd_act};
      end

      // Read clear fires on leaving the armed address or strobe.
      if (st_q.armed && (!rd_act || addr_s != st_q.ra)) begin
         st_d.armed = 1'b0;
         st_d.alarm_match_flag   = 1'b0;
         st_d.kick_event_flag   = 1'b0;
         st_d.watchdog_timeout_flag   = 1'b0;
      end else if (rd_act && addr_s == ADDR_FLAGS
                   && 32'(st_d.stab) >= ADDR_STABLE_CYC) begin
         st_d.armed = 1'b1;
      end

      // Writes are taken at the end of the strobe, as on the pins.
      if (wr_act) begin
         st_d.wv = 1'b1;
         st_d.wa = addr_s;
         st_d.wd = data_s;
      end else if (st_q.wv) begin
         st_d.wv     = 1'b0;
         st_d.reload = 1'b1;
         case (st_q.wa)
            ADDR_FLAGS: begin
               st_d.power_fail_output_keep = st_q.wd[FB_PRS];
               if (!st_q.wd[FB_PAB]) begin
                  st_d.power_hold_release = 1'b0;
               end else if (!st_q.alarm_match_flag && !st_q.kick_event_flag) begin
                  st_d.power_hold_release = 1'b1;
               end
               if (!st_q.wd[FB_TDF]) begin
                  st_d.alarm_match_flag = 1'b0;
               end
               st_d.kick_event_flag = st_q.wd[FB_KSF];
               if (!st_q.wd[FB_WDF]) begin
                  st_d.watchdog_timeout_flag = 1'b0;
               end
            end
            ADDR_CTRL: begin
               st_d.ctl = st_q.wd;
            end
            ADDR_MONTH: begin
               st_d.osc_stop_n = st_q.wd[MB_OSC];
            end
            default: begin
               st_d.wv = 1'b0;
            end
         endcase
      end

      // Hardware events override any clear in the same cycle.
      if (alarm_match_i && st_q.ctl[CB_TE]) begin
         st_d.alarm_match_flag = 1'b1;
      end
      if (kick_event_i) begin
         st_d.kick_event_flag = 1'b1;
      end
      if (wdog_timeout_i) begin
         st_d.watchdog_timeout_flag = 1'b1;
      end

      // Wake or kick forces the power request back on.
      if ((st_q.alarm_match_flag && st_q.ctl[CB_TPE]) || st_q.kick_event_flag) begin
         st_d.power_hold_release = 1'b0;
      end

      // Enable drops in the cycle after the reset pulse goes active.
      if (wd_if.active && !st_q.act_p) begin
         st_d.ctl[CB_WDE] = 1'b0;
      end
   end

   // Power-on reset defines every bit, including the undefined ones.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         st_q            <= '0;
         st_q.ctl        <= CTRL_RST;
         st_q.power_hold_release        <= PAB_RST;
         st_q.alarm_match_flag        <= FLAG_RST;
         st_q.kick_event_flag        <= FLAG_RST;
         st_q.watchdog_timeout_flag        <= FLAG_RST;
         st_q.osc_stop_n <= OSC_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // Read data leaves a flop; the drive enable follows the strobes.
   assign data_o    = st_q.rdata;
   assign data_oe_o = rd_act && (addr_s == ADDR_FLAGS || addr_s == ADDR_CTRL);

   // Interrupt floats once the supply is gone.
   assign irq_oe_o = interrupt_pending_flag && !pf_s;

   // In power fail the power request is held only if the keep bit asks for it.
   assign pwr_oe_o = !st_q.power_hold_release && (!pf_s || st_q.power_fail_output_keep);

   assign wdog_rst_n_o   = !wd_if.active;
   assign advance_o      = sec_tick_i && st_q.ctl[CB_TE];
   assign ram_addr_inc_o = ram_access_i && st_q.ctl[CB_BME];
   assign xtal_12p5_o    = st_q.ctl[CB_CS];
   assign osc_run_o      = !st_q.osc_stop_n;
   assign wdog_reload_o  = st_q.reload;

   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   a_irq_from_flags: assert property (
      irq_oe_o == (((st_q.alarm_match_flag & st_q.ctl[CB_TIE]) | (st_q.kick_event_flag & st_q.ctl[CB_KIE])
                    | (st_q.watchdog_timeout_flag & st_q.ctl[CB_WDE])) & !pf_s))
      else $error("Interrupt pin does not follow the enabled flags.");
   a_irq_release: assert property ($fell(interrupt_pending_flag) |-> !irq_oe_o)
      else $error("Interrupt held after pending flag cleared.");
   a_pab_wake_clr: assert property (
      (st_q.alarm_match_flag && st_q.ctl[CB_TPE]) || st_q.kick_event_flag |=> !st_q.power_hold_release)
      else $error("Hold-release not cleared by wake or kick.");
   a_pab_set_guard: assert property (
      $rose(st_q.power_hold_release) |-> $past(!st_q.alarm_match_flag && !st_q.kick_event_flag))
      else $error("Hold-release set while an event flag was set.");
   a_alarm_needs_te: assert property (
      $rose(st_q.alarm_match_flag) |-> $past(st_q.ctl[CB_TE]) && $past(alarm_match_i))
      else $error("Alarm flag set without transfers enabled.");
   a_wdf_set_wins: assert property (wdog_timeout_i |=> st_q.watchdog_timeout_flag)
      else $error("Watchdog timeout lost.");
   a_wde_after_rst: assert property (
      $fell(wdog_rst_n_o) |=> !st_q.ctl[CB_WDE] && !wdog_rst_n_o)
      else $error("Watchdog enable not cleared after reset pulse.");
   a_pwr_fail_float: assert property (
      pf_s && !st_q.power_fail_output_keep |-> !pwr_oe_o)
      else $error("Power request driven in power fail without keep.");
   a_pwr_hold: assert property (!pf_s |-> pwr_oe_o == !st_q.power_hold_release)
      else $error("Power request does not follow hold-release.");
   a_read_clear: assert property (
      st_q.armed && !rd_act && !alarm_match_i && !kick_event_i && !wdog_timeout_i
      |=> !st_q.alarm_match_flag && !st_q.kick_event_flag && !st_q.watchdog_timeout_flag && !interrupt_pending_flag && !irq_oe_o)
      else $error("Flag read did not clear the flags.");
   a_te_gates_tick: assert property (advance_o == (sec_tick_i && st_q.ctl[CB_TE]))
      else $error("Advance not gated by transfer enable.");

   c_read_clear: cover property (st_q.armed ##1 !st_q.armed);
   c_single_shot: cover property (wd_if.start ##[1:4] !st_q.ctl[CB_WDE]);
   c_alarm_wake: cover property ($rose(st_q.alarm_match_flag) ##1 !st_q.power_hold_release ##0 pwr_oe_o);
endmodule : rsc_top

/* File: inc/rsc_pkg.sv */
// Purpose: Constants for the clock/calendar flag and control register block.
// Assumes: 25 MHz system clock; register offsets on a 5-bit byte address bus.
// Notes:   Bit positions index the byte of each register.
package rsc_pkg;
   localparam int unsigned ADDR_W     = 5;
   localparam logic [4:0]  ADDR_MONTH = 5'h05;
   localparam logic [4:0]  ADDR_FLAGS = 5'h0e;
   localparam logic [4:0]  ADDR_CTRL  = 5'h0f;

   // Flag register bit positions.
   localparam int unsigned FB_MBL  = 7;
   localparam int unsigned FB_ABL  = 6;
   localparam int unsigned FB_PRS  = 5;
   localparam int unsigned FB_PAB  = 4;
   localparam int unsigned FB_TDF  = 3;
   localparam int unsigned FB_KSF  = 2;
   localparam int unsigned FB_WDF  = 1;
   localparam int unsigned FB_INTERRUPT_PENDING_FLAG = 0;

   // Control register bit positions.
   localparam int unsigned CB_TE  = 7;
   localparam int unsigned CB_CS  = 6;
   localparam int unsigned CB_BME = 5;
   localparam int unsigned CB_TPE = 4;
   localparam int unsigned CB_TIE = 3;
   localparam int unsigned CB_KIE = 2;
   localparam int unsigned CB_WDE = 1;
   localparam int unsigned CB_WDS = 0;

   // Oscillator stop bit inside the month register.
   localparam int unsigned MB_OSC = 7;

   // Values after power-on reset.
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic       FLAG_RST = 1'b0;
   localparam logic       PAB_RST  = 1'b0;
   localparam logic       OSC_RST  = 1'b0;

   // Timing.
   localparam int unsigned CLK_HZ         = 25_000_000;
   localparam int unsigned CLK_NS         = 1_000_000_000 / CLK_HZ;
   localparam int unsigned ADDR_STABLE_NS = 15;
   localparam int unsigned ADDR_STABLE_CYC =
      (ADDR_STABLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned RST_PULSE_MS   = 40;
   localparam int unsigned RST_PULSE_CYC  = RST_PULSE_MS * (CLK_HZ / 1000);
endpackage : rsc_pkg

/* File: inc/rsc_wd_if.sv */
// Purpose: Carrier between the register core and the reset pulse timer.
// Assumes: Both ends on mclk_i.
// Notes:   start is a one-cycle request; active is the pulse level.
interface rsc_wd_if;
   logic start;
   logic active;
   modport ctl   (output start, input active);
   modport pulse (input start, output active);
endinterface : rsc_wd_if

/* File: rtl/rsc_pin_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Inputs asynchronous to mclk_i.
// Notes:   A bit changes only once stages two and three agree.
module rsc_pin_sync #(
   parameter int unsigned W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         mclk_i,   // System clock.
   input  wire logic         reset_i,  // Synchronous reset.
   input  wire logic [W-1:0] async_i,  // Raw pins.
   output logic      [W-1:0] sync_o    // Filtered, synchronised value.
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } rsc_sync_t;

   rsc_sync_t st_q;
   rsc_sync_t st_d;

   // Stage one feeds only stage two; the filter looks at two and three.
   always_comb begin
      st_d    = st_q;
      st_d.s1 = async_i;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      st_d.q  = (st_q.s2 & st_q.s3) | (st_q.q & (st_q.s2 ^ st_q.s3));
   end

   // Reset to idle levels so a bus strobe does not appear active.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         st_q <= {INIT, INIT, INIT, INIT};
      end else begin
         st_q <= st_d;
      end
   end

   assign sync_o = st_q.q;
endmodule : rsc_pin_sync

/* File: rtl/rsc_rst_pulse.sv */
// Purpose: Single-shot watchdog reset pulse timer.
// Assumes: CYC of at least 8 cycles.
// Notes:   A start while the pulse runs is ignored.
module rsc_rst_pulse #(
   parameter int unsigned CYC = rsc_pkg::RST_PULSE_CYC
) (
   input  wire logic mclk_i,   // System clock.
   input  wire logic reset_i,  // Synchronous reset.
   rsc_wd_if.pulse   wd        // Start request and pulse level.
);
   import rsc_pkg::*;
   localparam int unsigned CW = $clog2(CYC + 1);

   typedef struct packed {
      logic          active;
      logic [CW-1:0] cnt;
   } rsc_pulse_t;

   rsc_pulse_t st_q;
   rsc_pulse_t st_d;

   // Hold the pulse for exactly CYC cycles.
   always_comb begin
      st_d = st_q;
      if (st_q.active) begin
         if (st_q.cnt == '0) begin
            st_d.active = 1'b0;
         end else begin
            st_d.cnt = st_q.cnt - CW'(1);
         end
      end else if (wd.start) begin
         st_d.active = 1'b1;
         st_d.cnt    = CW'(CYC - 1);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign wd.active = st_q.active;

   a_rst_hold_len: assert property (@(posedge mclk_i) disable iff (reset_i)
      $rose(st_q.active) |-> st_q.active [*8])
      else $error("Reset pulse ended too early.");
   c_rst_pulse_end: cover property (@(posedge mclk_i) disable iff (reset_i)
      $fell(st_q.active));
endmodule : rsc_rst_pulse

/* File: test/rsc_host_model.sv */
// Purpose: Host processor model on the asynchronous byte-wide register bus.
// Assumes: Strobes change just after a rising edge; the pin filter needs four cycles.
// Notes:   Data lines switch to the inverse of the last byte two cycles after the write strobes rise.
module rsc_host_model (
   input  wire logic                       mclk_i,   // System clock.
   input  wire logic [7:0]                 rdata_i,  // Resolved data bus.
   input  wire logic                       rd_oe_i,  // Device drives the bus.
   output logic                            ce_n_o,   // Chip select, low.
   output logic                            oe_n_o,   // Read strobe, low.
   output logic                            we_n_o,   // Write strobe, low.
   output logic [rsc_pkg::ADDR_W-1:0]      addr_o,   // Byte address.
   output logic [7:0]                      wdata_o,  // Host data drive.
   output logic [8:0]                      rd_o,     // Drive flag and byte of last read.
   output logic                            rd_vld_o  // Pulse when rd_o is fresh.
);
   timeunit 1ns;
   timeprecision 1ps;
   import rsc_pkg::*;
   int wr_cnt = 0;

   // Idle bus; strobes high so nothing is seen as a request.
   initial begin
      ce_n_o   = 1'b1;
      oe_n_o   = 1'b1;
      we_n_o   = 1'b1;
      addr_o   = '0;
      wdata_o  = 8'h5a;
      rd_o     = 9'h000;
      rd_vld_o = 1'b0;
   end

   // Eight cycles of strobe leave margin over the four-cycle filter delay.
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr_o  <= a;
      wdata_o <= d;
      ce_n_o  <= 1'b0;
      we_n_o  <= 1'b0;
      repeat (8) @(posedge mclk_i);
      ce_n_o  <= 1'b1;
      we_n_o  <= 1'b1;
      wr_cnt++;
      repeat (2) @(posedge mclk_i);
      wdata_o <= ~d;
      repeat (5) @(posedge mclk_i);
   endtask : wr

   // Data is taken at the edge that releases the strobes.
   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge mclk_i);
      addr_o <= a;
      ce_n_o <= 1'b0;
      oe_n_o <= 1'b0;
      repeat (8) @(posedge mclk_i);
      rd_o     <= rd_oe_i ? {1'b1, rdata_i} : 9'h000;
      rd_vld_o <= 1'b1;
      ce_n_o   <= 1'b1;
      oe_n_o   <= 1'b1;
      @(posedge mclk_i);
      rd_vld_o <= 1'b0;
      repeat (6) @(posedge mclk_i);
   endtask : rd
endmodule : rsc_host_model

/* File: test/rsc_top_tb.sv */
// Purpose: Self-checking bench for the flag and control register block.
// Assumes: Short reset pulse parameter; events are one-cycle pulses.
// Notes:   Expectations queue up; the monitor compares reads and pin snapshots.
module rsc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rsc_pkg::*;
   localparam int unsigned PULSE_CYC = 16;
   logic              mclk_i;
   logic              reset_i = 1'b1;
   logic              ce_n, oe_n, we_n, data_oe, rd_vld;
   logic [ADDR_W-1:0] addr;
   logic [7:0]        wdata, dout, bus, pins, v;
   logic              mbl = 1'b0, abl = 1'b0, pf = 1'b0, snap = 1'b0, tick = 1'b0;
   logic [2:0]        ev = 3'h0;
   logic              adv, inc, reload, xtal, osc, irq, power_on_request_n, rst_n;
   logic [8:0]        rd;
   logic [8:0]        exp_q[$];
   logic [31:0]       seed = 32'h0a1f;
   int                error_cnt = 0;
   int                comparisons = 0;
   int                reloads = 0;

   // Bus level resolved from both drivers; pin vector for snapshots.
   assign bus  = data_oe ? dout : wdata;
   assign pins = {rst_n, osc, xtal, power_on_request_n, irq, adv, inc, data_oe};

   rsc_top #(.RST_PULSE_CYC(PULSE_CYC)) DUT (
      .mclk_i(mclk_i), .reset_i(reset_i), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
      .addr_i(addr), .data_i(bus), .data_o(dout), .data_oe_o(data_oe),
      .main_batt_low_i(mbl), .aux_batt_low_i(abl), .power_fail_i(pf),
      .alarm_match_i(ev[0]), .kick_event_i(ev[1]), .wdog_timeout_i(ev[2]),
      .sec_tick_i(tick), .ram_access_i(tick), .advance_o(adv), .ram_addr_inc_o(inc),
      .wdog_reload_o(reload), .xtal_12p5_o(xtal), .osc_run_o(osc), .irq_oe_o(irq),
      .pwr_oe_o(power_on_request_n), .wdog_rst_n_o(rst_n));

   rsc_host_model host (
      .mclk_i(mclk_i), .rdata_i(bus), .rd_oe_i(data_oe), .ce_n_o(ce_n), .oe_n_o(oe_n),
      .we_n_o(we_n), .addr_o(addr), .wdata_o(wdata), .rd_o(rd), .rd_vld_o(rd_vld));

   // Clock at 25 MHz.
   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   task automatic check(input logic [8:0] seen, input logic [8:0] expd);
      comparisons++;
      if (seen !== expd) begin
         error_cnt++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, expd);
      end
   endtask : check

   task automatic finish_test();
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test

   task automatic done(input string name);
      $display("Test %s finished", name);
   endtask : done

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
      exp_q.push_back({1'b1, e});
      host.rd(a);
   endtask : rd_chk

   // Pin order: reset, osc run, xtal, pwr, irq, advance, ram step, data drive.
   task automatic pin_chk(input logic [7:0] e, input logic tk);
      @(posedge mclk_i);
      exp_q.push_back({1'b0, e});
      snap <= 1'b1;
      tick <= tk;
      @(posedge mclk_i);
      snap <= 1'b0;
      tick <= 1'b0;
   endtask : pin_chk

   // Event pulses are one cycle wide, then settle time for the flags.
   task automatic pulse(input int unsigned i);
      @(posedge mclk_i);
      ev[i] <= 1'b1;
      @(posedge mclk_i);
      ev[i] <= 1'b0;
      repeat (3) @(posedge mclk_i);
   endtask : pulse

   // Monitor takes the oldest note whenever a read or snapshot appears.
   always @(posedge mclk_i) begin
      if (reload === 1'b1) reloads++;
      if (rd_vld === 1'b1 || snap === 1'b1) begin
         check(rd_vld === 1'b1 ? rd : {1'b0, pins}, exp_q.pop_front());
      end
   end

   // Watchdog: the whole sequence needs well under three thousand cycles.
   initial begin
      repeat (3000) @(posedge mclk_i);
      error_cnt++;
      finish_test();
   end

   // Main sequence.
   initial begin
      repeat (4) @(posedge mclk_i);
      reset_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      rd_chk(ADDR_CTRL, 8'h00);
      rd_chk(ADDR_FLAGS, 8'h00);
      pin_chk(8'hd0, 1'b0);
      done("reset");
      mbl <= 1'b1;
      rd_chk(ADDR_FLAGS, 8'h80);
      mbl <= 1'b0;
      abl <= 1'b1;
      host.wr(ADDR_FLAGS, 8'hc0);
      rd_chk(ADDR_FLAGS, 8'h40);
      abl <= 1'b0;
      done("battery");
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         v = seed[7:0];
         host.wr(ADDR_CTRL, v);
         rd_chk(ADDR_CTRL, v);
         pin_chk({2'b11, v[6], 2'b10, v[7], v[5], 1'b0}, 1'b1);
      end
      done("random control");
      host.wr(ADDR_CTRL, 8'h88);
      pulse(0);
      pin_chk(8'hd8, 1'b0);
      rd_chk(ADDR_FLAGS, 8'h09);
      rd_chk(ADDR_FLAGS, 8'h00);
      pin_chk(8'hd0, 1'b0);
      host.wr(ADDR_CTRL, 8'h08);
      pulse(0);
      rd_chk(ADDR_FLAGS, 8'h00);
      done("alarm");
      host.wr(ADDR_CTRL, 8'h90);
      host.wr(ADDR_FLAGS, 8'h10);
      pin_chk(8'hc0, 1'b0);
      rd_chk(ADDR_FLAGS, 8'h10);
      pulse(0);
      pin_chk(8'hd0, 1'b0);
      rd_chk(ADDR_FLAGS, 8'h08);
      done("wake");
      host.wr(ADDR_CTRL, 8'h04);
      pulse(1);
      pin_chk(8'hd8, 1'b0);
      host.wr(ADDR_FLAGS, 8'h14);
      rd_chk(ADDR_FLAGS, 8'h05);
      host.wr(ADDR_FLAGS, 8'h04);
      rd_chk(ADDR_FLAGS, 8'h05);
      host.wr(ADDR_FLAGS, 8'h04);
      host.wr(ADDR_FLAGS, 8'h00);
      rd_chk(ADDR_FLAGS, 8'h00);
      host.wr(ADDR_CTRL, 8'h00);
      pulse(1);
      pin_chk(8'hd0, 1'b0);
      rd_chk(ADDR_FLAGS, 8'h04);
      done("kick");
      host.wr(ADDR_CTRL, 8'h02);
      pulse(2);
      pin_chk(8'hd8, 1'b0);
      host.wr(ADDR_FLAGS, 8'h00);
      pin_chk(8'hd0, 1'b0);
      host.wr(ADDR_FLAGS, 8'h02);
      rd_chk(ADDR_FLAGS, 8'h00);
      host.wr(ADDR_CTRL, 8'h03);
      pulse(2);
      pin_chk(8'h50, 1'b0);
      rd_chk(ADDR_CTRL, 8'h01);
      repeat (PULSE_CYC) @(posedge mclk_i);
      pin_chk(8'hd0, 1'b0);
      rd_chk(ADDR_FLAGS, 8'h02);
      done("watchdog");
      host.wr(ADDR_FLAGS, 8'h20);
      pf <= 1'b1;
      repeat (6) @(posedge mclk_i);
      pin_chk(8'hd0, 1'b0);
      pf <= 1'b0;
      host.wr(ADDR_FLAGS, 8'h00);
      pf <= 1'b1;
      repeat (6) @(posedge mclk_i);
      pin_chk(8'hc0, 1'b0);
      pf <= 1'b0;
      done("power fail");
      host.wr(ADDR_MONTH, 8'h80);
      pin_chk(8'h90, 1'b0);
      host.wr(ADDR_MONTH, 8'h00);
      pin_chk(8'hd0, 1'b0);
      done("oscillator");
      exp_q.push_back(9'h000);
      host.rd(5'h13);
      check(9'(reloads), 9'(host.wr_cnt));
      done("bus");
      finish_test();
   end
endmodule : rsc_top_tb
